// file: core/bce_core.sv
// byte core: four-phase fetch, decode and execute with an apb view
// assumes program word valid at prog_addr before q4 of each cycle,
// and data_rdata valid one clock after data_rd and held until q3;
// clk_en low freezes every register, the bus answer included
`include "bce_defines.svh"
`default_nettype none

module bce_core #(
  parameter logic [11:0] PORT_ADDR = `BCE_PORT_ADDR
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // program memory
  output logic [20:0]      prog_addr,
  input  wire logic [15:0] prog_data,
  // data file registers
  output logic [11:0]      data_addr,
  output logic             data_rd,
  output logic             data_wr,
  output logic [7:0]       data_wdata,
  input  wire logic [7:0]  data_rdata,
  output logic             port_read,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  bce_pkg::bce_phase_e phase_q;
  bce_pkg::bce_phase_e phase_d;
  bce_pkg::bce_alu_s   alu;

  logic [20:0] pc_q;
  logic [15:0] instr_q;
  logic        flush_q;
  logic [7:0]  work_q;
  logic [7:0]  product_high_byte_q;
  logic [7:0]  product_low_byte_q;
  logic [3:0]  bank_q;
  logic [4:0]  flags_q;
  logic [7:0]  fval_q;
  logic        run_q;
  logic [20:0] prog_addr_q;
  logic [11:0] data_addr_q;
  logic        data_rd_q;
  logic        data_wr_q;
  logic [7:0]  data_wdata_q;
  logic        port_read_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // file register address from f, a and bank register
  function automatic logic [11:0] file_addr(input logic [15:0] iw,
                                            input logic [3:0]  bank);
    logic [7:0] f;
    f = iw[`BCE_F_MSB:`BCE_F_LSB];
    if (iw[`BCE_A_BIT])
      return {bank, f};
    else if (f < `BCE_ACC_SPLIT)
      return {`BCE_ACC_LO_BANK, f};
    else
      return {`BCE_ACC_HI_BANK, f};
  endfunction

  bce_alu u_alu (
    .instr (instr_q),
    .flush (flush_q),
    .work  (work_q),
    .fval  (fval_q),
    .res   (alu)
  );

  // phase sequencing, held between instructions while stopped
  wire step   = clk_en && (run_q || (phase_q != bce_pkg::BCE_Q1));
  wire is_q1  = step && (phase_q == bce_pkg::BCE_Q1);
  wire is_q2  = step && (phase_q == bce_pkg::BCE_Q2);
  wire is_q3  = step && (phase_q == bce_pkg::BCE_Q3);
  wire is_q4  = step && (phase_q == bce_pkg::BCE_Q4);

  always_comb begin
    unique case (phase_q)
      bce_pkg::BCE_Q1: phase_d = bce_pkg::BCE_Q2;
      bce_pkg::BCE_Q2: phase_d = bce_pkg::BCE_Q3;
      bce_pkg::BCE_Q3: phase_d = bce_pkg::BCE_Q4;
      bce_pkg::BCE_Q4: phase_d = bce_pkg::BCE_Q1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      phase_q <= bce_pkg::BCE_Q1;
    else if (step)
      phase_q <= phase_d;
  end

  // jump target from second word and first-word literal
  wire [11:0] jump_hi = prog_data[11:0];
  wire [7:0]  jump_lo = instr_q[7:0];
  wire [19:0] jump_k  = {jump_hi, jump_lo};
  wire [20:0] jump_pc = {jump_k, 1'b0};
  wire [20:0] pc_inc  = pc_q + `BCE_PC_STEP;
  wire [20:0] pc_next = alu.is_jump ? jump_pc : pc_inc;
  wire [11:0] faddr   = file_addr(instr_q, bank_q);

  // apb decode
  wire apb_acc  = psel && penable;
  wire apb_done = apb_acc && pready_q;
  wire apb_wr   = apb_done && pwrite;
  wire hit_ctrl = (paddr == `BCE_REG_CTRL);
  wire hit_stat = (paddr == `BCE_REG_STATUS);
  wire hit_work = (paddr == `BCE_REG_WORK);
  wire hit_prod = (paddr == `BCE_REG_PROD);
  wire hit_bank = (paddr == `BCE_REG_BANK);
  wire hit_pc   = (paddr == `BCE_REG_PC);
  wire hit_any  = hit_ctrl || hit_stat || hit_work || hit_prod ||
                  hit_bank || hit_pc;
  wire stopped  = !run_q && (phase_q == bce_pkg::BCE_Q1);
  wire [31:0] rd_ctrl = {31'h00000000, run_q};
  wire [31:0] rd_stat = {26'h0000000, stopped, flags_q};
  wire [31:0] rd_work = {24'h000000, work_q};
  wire [31:0] rd_prod = {16'h0000, product_high_byte_q, product_low_byte_q};
  wire [31:0] rd_bank = {28'h0000000, bank_q};
  wire [31:0] rd_pc   = {11'h000, pc_q};
  wire [31:0] rd_mux  =
    hit_ctrl ? rd_ctrl :
    hit_stat ? rd_stat :
    hit_work ? rd_work :
    hit_prod ? rd_prod :
    hit_bank ? rd_bank :
    hit_pc   ? rd_pc   : 32'h00000000;

  // bus writes; work and pc only while stopped
  wire       bus_wr      = clk_en && apb_wr;
  wire       bus_wr_ctrl = bus_wr && hit_ctrl;
  wire       bus_wr_work = bus_wr && hit_work && stopped;
  wire       bus_wr_bank = bus_wr && hit_bank;
  wire       bus_wr_pc   = bus_wr && hit_pc && stopped;
  wire       run_d       = pwdata[0];
  wire [3:0] bank_d      = pwdata[3:0];

  // apb answer one clock after the first access edge
  wire        apb_first = apb_acc && !pready_q;
  wire        pready_d  = apb_first;
  wire        pslverr_d = apb_first && !hit_any;
  wire [31:0] prdata_d  = (apb_first && !pwrite) ? rd_mux : 32'h00000000;

  // next values on the cpu side
  wire        pc_load    = is_q4 || bus_wr_pc;
  wire [20:0] pc_d       = is_q4 ? pc_next : pwdata[20:0];
  wire        flush_d    = is_q4 ? alu.is_jump : 1'b1;
  wire [15:0] instr_d    = prog_data;
  wire [7:0]  fval_d     = data_rdata;
  wire        data_rd_d  = is_q1 && alu.uses_file;
  wire        port_rd_d  = data_rd_d && (faddr == PORT_ADDR);
  wire        data_wr_d  = is_q4 && alu.wr_file;
  wire [7:0]  wdata_d    = alu.result;
  wire        work_load  = (is_q4 && alu.wr_work) || bus_wr_work;
  wire [7:0]  work_d     = is_q4 ? alu.result : pwdata[7:0];
  wire        prod_load  = is_q4 && alu.wr_prod;
  wire [7:0]  mul_hi     = alu.product[15:8];
  wire [7:0]  mul_lo     = alu.product[7:0];
  wire [4:0]  flags_keep = flags_q & ~alu.flag_mask;
  wire [4:0]  flags_new  = alu.flags & alu.flag_mask;
  wire [4:0]  flags_d    = flags_keep | flags_new;

  // fetch and program counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      pc_q <= `BCE_RST_PC;
    else if (pc_load)
      pc_q <= pc_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      prog_addr_q <= `BCE_RST_PC;
    else if (pc_load)
      prog_addr_q <= pc_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      instr_q <= `BCE_NOP_WORD;
    else if (is_q4)
      instr_q <= instr_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      flush_q <= 1'b1;
    else if (pc_load)
      flush_q <= flush_d;
  end

  // file register read phase, also when only writing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      data_addr_q <= `BCE_RST_ADDR;
    else if (is_q1)
      data_addr_q <= faddr;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      data_rd_q <= 1'b0;
    else if (clk_en)
      data_rd_q <= data_rd_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      port_read_q <= 1'b0;
    else if (clk_en)
      port_read_q <= port_rd_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      fval_q <= `BCE_RST_BYTE;
    else if (is_q3)
      fval_q <= fval_d;
  end

  // write phase: destination, product pair, flags
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      data_wr_q <= 1'b0;
    else if (clk_en)
      data_wr_q <= data_wr_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      data_wdata_q <= `BCE_RST_BYTE;
    else if (is_q4)
      data_wdata_q <= wdata_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      work_q <= `BCE_RST_BYTE;
    else if (work_load)
      work_q <= work_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      product_high_byte_q <= `BCE_RST_BYTE;
    else if (prod_load)
      product_high_byte_q <= mul_hi;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      product_low_byte_q <= `BCE_RST_BYTE;
    else if (prod_load)
      product_low_byte_q <= mul_lo;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      flags_q <= `BCE_RST_FLAGS;
    else if (is_q4)
      flags_q <= flags_d;
  end

  // control and bank registers over apb
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      run_q <= 1'b0;
    else if (bus_wr_ctrl)
      run_q <= run_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      bank_q <= `BCE_RST_BANK;
    else if (bus_wr_bank)
      bank_q <= bank_d;
  end

  // apb answer: one wait state, error on unmapped offsets
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      pready_q <= 1'b0;
    else if (clk_en)
      pready_q <= pready_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      pslverr_q <= 1'b0;
    else if (clk_en)
      pslverr_q <= pslverr_d;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      prdata_q <= 32'h00000000;
    else if (clk_en)
      prdata_q <= prdata_d;
  end

  assign prog_addr  = prog_addr_q;
  assign data_addr  = data_addr_q;
  assign data_rd    = data_rd_q;
  assign data_wr    = data_wr_q;
  assign data_wdata = data_wdata_q;
  assign port_read  = port_read_q;
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;

endmodule // bce_core

`default_nettype wire

// file: include/bce_defines.svh
// constants of the byte core: opcodes, field positions, bus map, resets
// assumes inclusion by bare name from the package and the core modules
`ifndef BCE_DEFINES_SVH
`define BCE_DEFINES_SVH

// instruction fields
`define BCE_IW            16
`define BCE_F_LSB         0
`define BCE_F_MSB         7
`define BCE_A_BIT         8
`define BCE_D_BIT         9
`define BCE_B_LSB         9
`define BCE_B_MSB         11
`define BCE_MUL_A_BIT     8

// opcode patterns
`define BCE_OP_OR_WORKING_WITH_REGISTER      6'b000100
`define BCE_OP_INCREMENT_REGISTER       6'b001010
`define BCE_OP_OR_LITERAL_INTO_WORKING      8'h09
`define BCE_OP_MULTIPLY_LITERAL      8'h0D
`define BCE_OP_MULTIPLY_REGISTER      7'b0000001
`define BCE_OP_BCF        4'h9
`define BCE_OP_ABSOLUTE_JUMP       8'hEF
`define BCE_OP_CALL       7'b1110110
`define BCE_OP_LFSR       8'hEE
`define BCE_OP_MOVFF      4'hC
`define BCE_OP_SECOND     4'hF
`define BCE_NOP_WORD      16'h0000

// status flag positions
`define BCE_FL_C          0
`define BCE_FL_DC         1
`define BCE_FL_Z          2
`define BCE_FL_OV         3
`define BCE_FL_N          4
`define BCE_FL_W          5

// data address forming and program counter step
`define BCE_ACC_SPLIT     8'h80
`define BCE_ACC_LO_BANK   4'h0
`define BCE_ACC_HI_BANK   4'hF
`define BCE_PC_STEP       21'h000002

// apb register byte offsets
`define BCE_AW            8
`define BCE_REG_CTRL      8'h00
`define BCE_REG_STATUS    8'h04
`define BCE_REG_WORK      8'h08
`define BCE_REG_PROD      8'h0C
`define BCE_REG_BANK      8'h10
`define BCE_REG_PC        8'h14

// reset values and port address
`define BCE_RST_PC        21'h000000
`define BCE_RST_BYTE      8'h00
`define BCE_RST_BANK      4'h0
`define BCE_RST_ADDR      12'h000
`define BCE_RST_FLAGS     5'h00
`define BCE_PORT_ADDR     12'hF81

`endif

// file: include/bce_pkg.sv
// types shared by the byte core and its alu
// assumes bce_defines.svh on the include path
`include "bce_defines.svh"
`default_nettype none

package bce_pkg;

  typedef enum logic [1:0] {
    BCE_Q1 = 2'b00,
    BCE_Q2 = 2'b01,
    BCE_Q3 = 2'b10,
    BCE_Q4 = 2'b11
  } bce_phase_e;

  typedef struct packed {
    logic        uses_file;
    logic        wr_work;
    logic        wr_file;
    logic        wr_prod;
    logic        is_jump;
    logic [7:0]  result;
    logic [15:0] product;
    logic [4:0]  flags;
    logic [4:0]  flag_mask;
  } bce_alu_s;

endpackage

`default_nettype wire

// file: core/bce_alu.sv
// combinational decode and execute of one instruction word
// assumes operand byte already read from the addressed file register
`include "bce_defines.svh"
`default_nettype none

module bce_alu (
  // instruction and operands
  input  wire logic [15:0]     instr,
  input  wire logic            flush,
  input  wire logic [7:0]      work,
  input  wire logic [7:0]      fval,
  // result
  output bce_pkg::bce_alu_s    res
);

  wire [7:0] op_hi     = instr[15:8];
  wire [7:0] lit       = instr[`BCE_F_MSB:`BCE_F_LSB];
  wire       dst       = instr[`BCE_D_BIT];
  wire [2:0] bit_sel   = instr[`BCE_B_MSB:`BCE_B_LSB];

  // a lone second word or a flushed slot decodes as nothing
  wire live     = !flush && (instr[15:12] != `BCE_OP_SECOND);
  wire is_or_working_with_register = live && (instr[15:10] == `BCE_OP_OR_WORKING_WITH_REGISTER);
  wire is_increment_register  = live && (instr[15:10] == `BCE_OP_INCREMENT_REGISTER);
  wire is_or_literal_into_working = live && (op_hi == `BCE_OP_OR_LITERAL_INTO_WORKING);
  wire is_multiply_literal = live && (op_hi == `BCE_OP_MULTIPLY_LITERAL);
  wire is_multiply_register = live && (instr[15:9] == `BCE_OP_MULTIPLY_REGISTER);
  wire is_bcf   = live && (instr[15:12] == `BCE_OP_BCF);
  wire is_absolute_jump  = live && (op_hi == `BCE_OP_ABSOLUTE_JUMP);

  wire [8:0] inc_sum = {1'b0, fval} + 9'h001;
  wire [4:0] inc_low = {1'b0, fval[3:0]} + 5'h01;
  wire [7:0] or_f    = work | fval;
  wire [7:0] or_k    = work | lit;
  wire [7:0] mul_src = is_multiply_literal ? lit : fval;
  wire [15:0] prod   = {8'h00, work} * {8'h00, mul_src};
  wire [7:0] bit_clr = fval & ~(8'h01 << bit_sel);

  function automatic logic [4:0] nz_flags(input logic [7:0] v);
    logic [4:0] f;
    f = 5'h00;
    f[`BCE_FL_N] = v[7];
    f[`BCE_FL_Z] = (v == 8'h00);
    return f;
  endfunction

  logic [4:0] inc_fl;
  always_comb begin
    inc_fl = nz_flags(inc_sum[7:0]);
    inc_fl[`BCE_FL_C]  = inc_sum[8];
    inc_fl[`BCE_FL_DC] = inc_low[4];
    inc_fl[`BCE_FL_OV] = !fval[7] && inc_sum[7];
  end

  localparam logic [4:0] NZ_MASK  = (5'h01 << `BCE_FL_N) |
                                    (5'h01 << `BCE_FL_Z);
  localparam logic [4:0] ALL_MASK = 5'h1F;

  always_comb begin
    res           = '0;
    res.uses_file = is_or_working_with_register || is_increment_register || is_multiply_register || is_bcf;
    res.is_jump   = is_absolute_jump;
    res.product   = prod;
    if (is_or_working_with_register) begin
      res.result    = or_f;
      res.wr_work   = !dst;
      res.wr_file   = dst;
      res.flags     = nz_flags(or_f);
      res.flag_mask = NZ_MASK;
    end else if (is_increment_register) begin
      res.result    = inc_sum[7:0];
      res.wr_work   = !dst;
      res.wr_file   = dst;
      res.flags     = inc_fl;
      res.flag_mask = ALL_MASK;
    end else if (is_or_literal_into_working) begin
      res.result    = or_k;
      res.wr_work   = 1'b1;
      res.flags     = nz_flags(or_k);
      res.flag_mask = NZ_MASK;
    end else if (is_multiply_literal || is_multiply_register) begin
      res.wr_prod   = 1'b1;
    end else if (is_bcf) begin
      res.result    = bit_clr;
      res.wr_file   = 1'b1;
    end
  end

endmodule // bce_alu

`default_nettype wire

// file: tb/bce_chk.sv
// checker on the byte core ports: phase pacing, rmw order, jump, apb
// assumes clk_en held high, so one phase per clock
`default_nettype none

module bce_chk #(
  parameter logic [11:0] PORT_ADDR = 12'hF81
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // program and data side
  input wire logic [20:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic [11:0] data_addr,
  input wire logic        data_rd,
  input wire logic        data_wr,
  input wire logic        port_read,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_pace;
    $changed(prog_addr) |=> $stable(prog_addr) [*3];
  endproperty
  a_pace: assert property (p_pace) else $error("fetch too fast");

  property p_rdp;
    data_rd |=> !data_rd [*3];
  endproperty
  a_rdp: assert property (p_rdp) else $error("read pulse");

  property p_rmw;
    data_wr |-> $past(data_rd, 3) && data_addr == $past(data_addr, 3);
  endproperty
  a_rmw: assert property (p_rmw) else $error("write without read");

  property p_port;
    port_read == (data_rd && data_addr == PORT_ADDR);
  endproperty
  a_port: assert property (p_port) else $error("port read");

  property p_jump;
    $changed(prog_addr) && $past(prog_data[15:12]) == 4'hF
      && $past(prog_data[15:8], 5) == 8'hEF |->
      prog_addr == {$past(prog_data[11:0]), $past(prog_data[7:0], 5), 1'b0};
  endproperty
  a_jump: assert property (p_jump) else $error("jump");

  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("apb wait");

  property p_once;
    pready |=> !pready;
  endproperty
  a_once: assert property (p_once) else $error("apb ready held");

  property p_err;
    pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0);
  endproperty
  a_err: assert property (p_err) else $error("apb error flag");

  c_jump: cover property ($changed(prog_addr) && prog_addr == 21'h20);
  c_port: cover property (port_read);
  c_err: cover property (pready && pslverr);
endmodule // bce_chk

bind bce_core bce_chk #(.PORT_ADDR(PORT_ADDR)) i_chk (
  .ref_clk, .reset, .prog_addr, .prog_data, .data_addr, .data_rd,
  .data_wr, .port_read, .psel, .penable, .paddr, .pready, .pslverr
);
`default_nettype wire

// file: tb/bce_mem.sv
// program memory and data file model facing the byte core
// assumes read data wanted the clock after data_rd, held into q3
`default_nettype none

module bce_mem (
  // clock
  input  wire logic        ref_clk,
  // program side
  input  wire logic [20:0] prog_addr,
  output logic      [15:0] prog_data,
  // data side
  input  wire logic [11:0] data_addr,
  input  wire logic        data_rd,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  output logic      [7:0]  data_rdata,
  input  wire logic        port_read
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rom [0:63];
  logic [7:0]  ram [0:4095];
  int          ports;

  // words above the table read as nop
  assign prog_data = (prog_addr < 21'h80) ? rom[prog_addr[6:1]] : 16'h0000;

  initial begin
    ports = 0;
    data_rdata = 8'h00;
    for (int i = 0; i < 64; i++)
      rom[i] = 16'h0000;
  end

  // read data valid one clock, then scrambled
  always @(posedge ref_clk) begin
    data_rdata <= data_rd ? ram[data_addr] : ~data_rdata;
    if (data_wr)
      ram[data_addr] <= data_wdata;
    if (port_read)
      ports <= ports + 1;
  end
endmodule // bce_mem
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the byte core: apb setup, short program, results
// assumes bce_core and the memory model, clk_en held high
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [20:0] prog_addr;
  wire  [15:0] prog_data;
  wire  [11:0] data_addr;
  wire  [7:0]  data_wdata;
  wire  [7:0]  data_rdata;
  wire         data_rd;
  wire         data_wr;
  wire         port_read;
  logic [31:0] r;
  logic        e;
  int          err_total = 0;
  int          checks = 0;

  always #4 ref_clk = ~ref_clk;

  bce_core i_dut (
    .ref_clk, .reset, .clk_en(1'b1), .prog_addr, .prog_data, .data_addr,
    .data_rd, .data_wr, .data_wdata, .data_rdata, .port_read, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
  );

  bce_mem i_mem (
    .ref_clk, .prog_addr, .prog_data, .data_addr, .data_rd, .data_wr,
    .data_wdata, .data_rdata, .port_read
  );

  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic fail(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
      fail($sformatf("got %h want %h", got, exp));
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail("apb hang");
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  // reset values, refused offset
  task automatic t_idle();
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h20);
    rd(8'h0C, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  // registers set while stopped, product read only
  task automatic t_setup();
    apb(1'b1, 8'h08, 32'h91);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h0C, 32'hFFFF);
    rd(8'h08, 32'h91);
    rd(8'h10, 32'h2);
    rd(8'h0C, 32'h0);
  endtask

  // program: or, mul, inc, jump over trap, lone word, bit clear, mul, or
  task automatic t_run();
    int n;
    i_mem.rom[0] = 16'h1010;
    i_mem.rom[1] = 16'h0210;
    i_mem.rom[2] = 16'h2B20;
    i_mem.rom[3] = 16'hEF10;
    i_mem.rom[4] = 16'hF000;
    i_mem.rom[5] = 16'h09FF;
    i_mem.rom[16] = 16'hF0FF;
    i_mem.rom[17] = 16'h9281;
    i_mem.rom[18] = 16'h0DC4;
    i_mem.rom[19] = 16'h0904;
    i_mem.ram[12'h010] = 8'h13;
    i_mem.ram[12'h220] = 8'hFF;
    i_mem.ram[12'hF81] = 8'hFF;
    apb(1'b1, 8'h00, 32'h1);
    n = 0;
    while (prog_addr !== 21'h30 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      fail("program stuck");
      conclude();
    end
    apb(1'b1, 8'h00, 32'h0);
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (r[5] !== 1'b1 && n < 8);
    if (r[5] !== 1'b1) begin
      fail("core never stopped");
      conclude();
    end
    chk(r, 32'h33);
    rd(8'h08, 32'h97);
    rd(8'h0C, 32'h708C);
    chk({24'h0, i_mem.ram[12'h220]}, 32'h0);
    chk({24'h0, i_mem.ram[12'h010]}, 32'h13);
    chk({24'h0, i_mem.ram[12'hF81]}, 32'hFD);
    chk(i_mem.ports, 32'h1);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_idle();
    t_setup();
    t_run();
    conclude();
  end
endmodule // testbench
`default_nettype wire
